/* File: design/dtc_timer_core.sv */
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
// -------------------------------------------------------------
// Summary of operation
// - second unit gating set: counts only while run and request b pin high.
// - first unit gating set: counts only while run and request a pin high.
// - second unit source: 0 prescaled clock, 1 falling edges on its pin.
// - first unit source: 0 prescaled clock, 1 falling edges on its pin.
// - second unit modes: 13-bit, 16-bit, 8-bit reload, stopped.
// - first unit modes: 13-bit, 16-bit, 8-bit reload, two 8-bit counters.
// - second overflow flag set on overflow, cleared on vector.
// - first overflow flag set on overflow, cleared on vector.
// - second run bit enables the second unit.
// - first run bit enables the first unit.
// - edge mode: request b flag set on falling edge, vector clears, software sets.
// - level mode: request b flag follows low pin, writes ignored.
// - request b type: 0 level low, 1 falling edge.
// - edge mode: request a flag set on falling edge, vector clears, software sets.
// - level mode: request a flag follows low pin, writes ignored.
// - request a type: 0 level low, 1 falling edge.
// - 13-bit mode uses low five bits plus high byte, rolls over, flags.
// - reload mode reloads low byte from high byte on overflow.
// - first unit split: second unit holds; first high byte uses second run and flag.
// - prescale select 0 divides by 12, 1 by 4; ignored for pin counting.
// -------------------------------------------------------------
module dtc_timer_core
	import dtc_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       write_in,
	input  wire logic       read_in,
	output logic      [7:0] rdata_out,
	input  wire logic       first_unit_count_pin_in,
	input  wire logic       second_unit_count_pin_in,
	input  wire logic       ext_request_a_pin_in,
	input  wire logic       ext_request_b_pin_in,
	input  wire logic       vector_first_unit_in,
	input  wire logic       vector_second_unit_in,
	input  wire logic       vector_request_a_in,
	input  wire logic       vector_request_b_in,
	output logic            first_unit_overflow_flag_out,
	output logic            second_unit_overflow_flag_out,
	output logic            ext_request_a_flag_out,
	output logic            ext_request_b_flag_out
);
	// -------------------------------------------------------------
	// state and synchronised pin terms
	// -------------------------------------------------------------
	// whole block state lives in one packed struct
	dtc_state_t state_reg;
	dtc_state_t state_next;

	// count pins feed edges only; request pins feed levels and edges
	logic        t0_fall;
	logic        t1_fall;
	logic        req_a_level;
	logic        req_a_fall;
	logic        req_b_level;
	logic        req_b_fall;

	// -------------------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------------------
	// all four pins cross into the system clock here
	// count pins: a counter only needs the falling edge, level left open
	dtc_pin_sync u_sync_t0 (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.pin_in    (first_unit_count_pin_in),
		.level_out (),
		.fall_out  (t0_fall)
	);
	dtc_pin_sync u_sync_t1 (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.pin_in    (second_unit_count_pin_in),
		.level_out (),
		.fall_out  (t1_fall)
	);
	// request pins: levels gate and drive level flags, edges set edge flags
	dtc_pin_sync u_sync_a (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.pin_in    (ext_request_a_pin_in),
		.level_out (req_a_level),
		.fall_out  (req_a_fall)
	);
	dtc_pin_sync u_sync_b (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.pin_in    (ext_request_b_pin_in),
		.level_out (req_b_level),
		.fall_out  (req_b_fall)
	);

	// -------------------------------------------------------------
	// next-state logic
	// -------------------------------------------------------------
	always_comb begin
		// scratch terms; each cleared first so no path leaves one open
		logic [1:0]  m0;
		logic [1:0]  m1;
		logic        tick_slow;
		logic        tick_fast;
		logic        clk0;
		logic        clk1;
		logic        en0;
		logic        en1;
		logic        en_hi0;
		logic [16:0] step0;
		logic [16:0] step1;
		logic        ovf0;
		logic        ovf1;
		logic        ovf_hi0;
		logic        edge_a;
		logic        edge_b;
		m0        = '0;
		m1        = '0;
		tick_slow = 1'b0;
		tick_fast = 1'b0;
		clk0      = 1'b0;
		clk1      = 1'b0;
		en0       = 1'b0;
		en1       = 1'b0;
		en_hi0    = 1'b0;
		step0     = '0;
		step1     = '0;
		ovf0      = 1'b0;
		ovf1      = 1'b0;
		ovf_hi0   = 1'b0;
		edge_a    = 1'b0;
		edge_b    = 1'b0;
		// hold by default; read data drop back to zero after one cycle
		state_next       = state_reg;
		state_next.rdata = RESET_BYTE;

		// -------------------------------------------------------------
		// counting
		// -------------------------------------------------------------
		// shared prescaler: one mod-12 count serves both divide ratios
		// limitation: never restarted, so a first tick comes 1 to 12 clocks after run
		tick_slow = (state_reg.div == DIV_LAST);
		tick_fast = (state_reg.div[1:0] == DIV_FAST_LAST);
		state_next.div = tick_slow ? 4'h0 : state_reg.div + 4'h1;
		clk0 = state_reg.psel[0] ? tick_fast : tick_slow;
		clk1 = state_reg.psel[1] ? tick_fast : tick_slow;

		// mode fields of both units
		m0 = {state_reg.mode[MODE_FIRST_UNIT_MODE_HI], state_reg.mode[MODE_FIRST_UNIT_MODE_LO]};
		m1 = {state_reg.mode[MODE_SECOND_UNIT_MODE_HI],
			state_reg.mode[MODE_SECOND_UNIT_MODE_LO]};

		// first unit enable: run, gate, source
		en0 = state_reg.ctrl[CTL_FIRST_UNIT_RUN]
			& (~state_reg.mode[MODE_FIRST_UNIT_GATING] | req_a_level)
			& (state_reg.mode[MODE_FIRST_UNIT_SOURCE] ? t0_fall : clk0);

		// second unit enable; stopped in its own mode 3 or by split mode
		en1 = state_reg.ctrl[CTL_SECOND_UNIT_RUN]
			& (~state_reg.mode[MODE_SECOND_UNIT_GATING] | req_b_level)
			& (state_reg.mode[MODE_SECOND_UNIT_SOURCE] ? t1_fall : clk1)
			& (m1 != MODE_SPLIT)
			& (m0 != MODE_SPLIT);

		// split mode: first high byte is a plain timer on the second run bit
		en_hi0 = (m0 == MODE_SPLIT) & state_reg.ctrl[CTL_SECOND_UNIT_RUN] & clk1;

		// counting steps per mode
		// 13-bit mode leaves the top three low-byte bits untouched
		step0 = dtc_step(m0, state_reg.hi0, state_reg.lo0);
		step1 = dtc_step(m1, state_reg.hi1, state_reg.lo1);
		ovf0  = en0 & step0[16];
		ovf1  = en1 & step1[16];
		ovf_hi0 = en_hi0 & (state_reg.hi0 == 8'hff);

		// commit steps; the split high-byte count is applied last so it wins
		if (en0) begin
			state_next.lo0 = step0[7:0];
			state_next.hi0 = step0[15:8]; // unchanged in split mode
		end
		if (en_hi0) begin
			state_next.hi0 = state_reg.hi0 + 8'h01;
		end
		if (en1) begin
			state_next.lo1 = step1[7:0];
			state_next.hi1 = step1[15:8];
		end

		// -------------------------------------------------------------
		// register writes
		// -------------------------------------------------------------
		// software writes to bytes override a count in the same cycle
		if (write_in) begin
			if (addr_in == ADDR_TIMER_MODE_SELECT) begin
				state_next.mode = wdata_in;
			end else if (addr_in == ADDR_TIMER_CONTROL_AND_EXT_IRQ) begin
				state_next.ctrl = wdata_in;
			end else if (addr_in == ADDR_FIRST_LOW) begin
				state_next.lo0 = wdata_in;
			end else if (addr_in == ADDR_SECOND_LOW) begin
				state_next.lo1 = wdata_in;
			end else if (addr_in == ADDR_FIRST_HIGH) begin
				state_next.hi0 = wdata_in;
			end else if (addr_in == ADDR_SECOND_HIGH) begin
				state_next.hi1 = wdata_in;
			end else if (addr_in == ADDR_PRESCALE_CONFIG_REG) begin
				state_next.psel = {wdata_in[PCFG_SECOND_UNIT_PRESCALE_SEL],
					wdata_in[PCFG_FIRST_UNIT_PRESCALE_SEL]};
			end
		end

		// -------------------------------------------------------------
		// flag updates
		// -------------------------------------------------------------
		// overflow flags: vector clears, a same-cycle overflow still wins
		if (vector_first_unit_in) begin
			state_next.ctrl[CTL_FIRST_UNIT_OVERFLOW_FLAG] = 1'b0;
		end
		if (ovf0) begin
			state_next.ctrl[CTL_FIRST_UNIT_OVERFLOW_FLAG] = 1'b1;
		end
		if (vector_second_unit_in) begin
			state_next.ctrl[CTL_SECOND_UNIT_OVERFLOW_FLAG] = 1'b0;
		end
		if (ovf1 | ovf_hi0) begin
			state_next.ctrl[CTL_SECOND_UNIT_OVERFLOW_FLAG] = 1'b1;
		end

		// request a: edge mode keeps write value unless vectored or edged
		edge_a = state_reg.ctrl[CTL_EXT_REQUEST_A_TYPE];
		if (edge_a) begin
			if (vector_request_a_in) begin
				state_next.ctrl[CTL_EXT_REQUEST_A_FLAG] = 1'b0;
			end
			if (req_a_fall) begin
				state_next.ctrl[CTL_EXT_REQUEST_A_FLAG] = 1'b1;
			end
		end else begin
			state_next.ctrl[CTL_EXT_REQUEST_A_FLAG] = ~req_a_level;
		end

		// request b: same scheme
		edge_b = state_reg.ctrl[CTL_EXT_REQUEST_B_TYPE];
		if (edge_b) begin
			if (vector_request_b_in) begin
				state_next.ctrl[CTL_EXT_REQUEST_B_FLAG] = 1'b0;
			end
			if (req_b_fall) begin
				state_next.ctrl[CTL_EXT_REQUEST_B_FLAG] = 1'b1;
			end
		end else begin
			state_next.ctrl[CTL_EXT_REQUEST_B_FLAG] = ~req_b_level;
		end

		// -------------------------------------------------------------
		// read back mux
		// -------------------------------------------------------------
		// read data, valid in the cycle after the strobe only
		if (read_in) begin
			if (addr_in == ADDR_TIMER_MODE_SELECT) begin
				state_next.rdata = state_reg.mode;
			end else if (addr_in == ADDR_TIMER_CONTROL_AND_EXT_IRQ) begin
				state_next.rdata = state_reg.ctrl;
			end else if (addr_in == ADDR_FIRST_LOW) begin
				state_next.rdata = state_reg.lo0;
			end else if (addr_in == ADDR_SECOND_LOW) begin
				state_next.rdata = state_reg.lo1;
			end else if (addr_in == ADDR_FIRST_HIGH) begin
				state_next.rdata = state_reg.hi0;
			end else if (addr_in == ADDR_SECOND_HIGH) begin
				state_next.rdata = state_reg.hi1;
			end else if (addr_in == ADDR_PRESCALE_CONFIG_REG) begin
				state_next.rdata[PCFG_SECOND_UNIT_PRESCALE_SEL] = state_reg.psel[1];
				state_next.rdata[PCFG_FIRST_UNIT_PRESCALE_SEL]  = state_reg.psel[0];
			end
		end
	end

	// -------------------------------------------------------------
	// state register
	// -------------------------------------------------------------
	// synchronous reset clears every field, prescaler phase included
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_reg.mode  <= RESET_BYTE;
			state_reg.ctrl  <= RESET_BYTE;
			state_reg.lo0   <= RESET_BYTE;
			state_reg.hi0   <= RESET_BYTE;
			state_reg.lo1   <= RESET_BYTE;
			state_reg.hi1   <= RESET_BYTE;
			state_reg.psel  <= RESET_PRESCALE;
			state_reg.div   <= 4'h0;
			state_reg.rdata <= RESET_BYTE;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state flops
	assign rdata_out                     = state_reg.rdata;
	assign first_unit_overflow_flag_out  = state_reg.ctrl[CTL_FIRST_UNIT_OVERFLOW_FLAG];
	assign second_unit_overflow_flag_out = state_reg.ctrl[CTL_SECOND_UNIT_OVERFLOW_FLAG];
	assign ext_request_a_flag_out        = state_reg.ctrl[CTL_EXT_REQUEST_A_FLAG];
	assign ext_request_b_flag_out        = state_reg.ctrl[CTL_EXT_REQUEST_B_FLAG];
endmodule

/* File: design/dtc_pkg.sv */
package dtc_pkg;

	// -------------------------------------------------------------
	// register offsets
	// -------------------------------------------------------------
	localparam logic [7:0] ADDR_TIMER_CONTROL_AND_EXT_IRQ = 8'h88;
	localparam logic [7:0] ADDR_TIMER_MODE_SELECT         = 8'h89;
	localparam logic [7:0] ADDR_FIRST_LOW                 = 8'h8a;
	localparam logic [7:0] ADDR_SECOND_LOW                = 8'h8b;
	localparam logic [7:0] ADDR_FIRST_HIGH                = 8'h8c;
	localparam logic [7:0] ADDR_SECOND_HIGH               = 8'h8d;
	localparam logic [7:0] ADDR_PRESCALE_CONFIG_REG       = 8'h8e;

	// -------------------------------------------------------------
	// mode register fields
	// -------------------------------------------------------------
	localparam int MODE_SECOND_UNIT_GATING = 7;
	localparam int MODE_SECOND_UNIT_SOURCE = 6;
	localparam int MODE_SECOND_UNIT_MODE_HI = 5;
	localparam int MODE_SECOND_UNIT_MODE_LO = 4;
	localparam int MODE_FIRST_UNIT_GATING  = 3;
	localparam int MODE_FIRST_UNIT_SOURCE  = 2;
	localparam int MODE_FIRST_UNIT_MODE_HI = 1;
	localparam int MODE_FIRST_UNIT_MODE_LO = 0;

	// -------------------------------------------------------------
	// control register fields
	// -------------------------------------------------------------
	localparam int CTL_SECOND_UNIT_OVERFLOW_FLAG = 7;
	localparam int CTL_SECOND_UNIT_RUN           = 6;
	localparam int CTL_FIRST_UNIT_OVERFLOW_FLAG  = 5;
	localparam int CTL_FIRST_UNIT_RUN            = 4;
	localparam int CTL_EXT_REQUEST_B_FLAG        = 3;
	localparam int CTL_EXT_REQUEST_B_TYPE        = 2;
	localparam int CTL_EXT_REQUEST_A_FLAG        = 1;
	localparam int CTL_EXT_REQUEST_A_TYPE        = 0;

	// -------------------------------------------------------------
	// prescale config fields and reset values
	// -------------------------------------------------------------
	localparam int PCFG_SECOND_UNIT_PRESCALE_SEL = 4;
	localparam int PCFG_FIRST_UNIT_PRESCALE_SEL  = 3;
	localparam logic [7:0] RESET_BYTE             = 8'h00;
	localparam logic [1:0] RESET_PRESCALE         = 2'h0;

	// -------------------------------------------------------------
	// modes and prescale counts
	// -------------------------------------------------------------
	localparam logic [1:0] MODE_COUNT13 = 2'h0;
	localparam logic [1:0] MODE_COUNT16 = 2'h1;
	localparam logic [1:0] MODE_RELOAD8 = 2'h2;
	localparam logic [1:0] MODE_SPLIT   = 2'h3;
	localparam int         DIV_SLOW     = 12;
	localparam int         DIV_FAST     = 4;
	localparam logic [3:0] DIV_LAST     = 4'(DIV_SLOW - 1);
	localparam logic [1:0] DIV_FAST_LAST = 2'(DIV_FAST - 1);
	localparam logic [12:0] MAX13       = 13'h1fff;

	// one counting step: {overflow, high byte, low byte}
	function automatic logic [16:0] dtc_step(input logic [1:0] m,
		input logic [7:0] hi, input logic [7:0] lo);
		logic [12:0] v13;
		logic [15:0] v16;
		logic [16:0] r;
		v13 = {hi, lo[4:0]} + 13'h0001;
		v16 = {hi, lo} + 16'h0001;
		case (m)
			MODE_COUNT13: begin
				r = {({hi, lo[4:0]} == MAX13), v13[12:5], lo[7:5], v13[4:0]};
			end
			MODE_COUNT16: begin
				r = {({hi, lo} == 16'hffff), v16};
			end
			MODE_RELOAD8: begin
				r = {(lo == 8'hff), hi, ((lo == 8'hff) ? hi : v16[7:0])};
			end
			default: begin
				r = {(lo == 8'hff), hi, v16[7:0]};
			end
		endcase
		return r;
	endfunction

	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] ctrl;
		logic [7:0] lo0;
		logic [7:0] hi0;
		logic [7:0] lo1;
		logic [7:0] hi1;
		logic [1:0] psel;
		logic [3:0] div;
		logic [7:0] rdata;
	} dtc_state_t;

endpackage

/* File: design/dtc_pin_sync.sv */
`timescale 1ns/1ns
// two-flop synchroniser with falling-edge detect on the settled samples
module dtc_pin_sync (
	input  wire logic clk_in,
	input  wire logic reset_in,
	input  wire logic pin_in,
	output logic      level_out,
	output logic      fall_out
);
	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// -------------------------------------------------------------
	// sampling
	// -------------------------------------------------------------
	// reset to high so an idle-high pin gives no false edge
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			prev_reg <= 1'b1;
		end else begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// edge from two settled samples only
	assign level_out = sync_reg;
	assign fall_out  = prev_reg & ~sync_reg;
endmodule

/* File: verification/dtc_timer_props.sv */
`timescale 1ns/1ns
// ----------------------------------------
// port checker for the timer core
// ----------------------------------------
module dtc_timer_props
	import dtc_pkg::*;
(
	input wire logic       clk_in,
	input wire logic       reset_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       write_in,
	input wire logic       read_in,
	input wire logic [7:0] rdata_out,
	input wire logic       first_unit_count_pin_in,
	input wire logic       second_unit_count_pin_in,
	input wire logic       ext_request_a_pin_in,
	input wire logic       ext_request_b_pin_in,
	input wire logic       vector_first_unit_in,
	input wire logic       vector_second_unit_in,
	input wire logic       vector_request_a_in,
	input wire logic       vector_request_b_in,
	input wire logic       first_unit_overflow_flag_out,
	input wire logic       second_unit_overflow_flag_out,
	input wire logic       ext_request_a_flag_out,
	input wire logic       ext_request_b_flag_out
);
	logic [7:0] mode_reg;
	logic [7:0] ctl_reg;

	// software copies; only run and type bits of ctl_reg are trusted
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mode_reg <= 8'h00;
			ctl_reg  <= 8'h00;
		end else if (write_in && addr_in == ADDR_TIMER_MODE_SELECT) begin
			mode_reg <= wdata_in;
		end else if (write_in && addr_in == ADDR_TIMER_CONTROL_AND_EXT_IRQ) begin
			ctl_reg <= wdata_in;
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);

	chk_mode_read: assert property (
		read_in && addr_in == ADDR_TIMER_MODE_SELECT |=> rdata_out == mode_reg)
		else $error("mode read back differs from last write");
	chk_rdata_idle: assert property (!read_in |=> rdata_out == 8'h00)
		else $error("read data present without a read");
	// six samples cover the two-flop lag and the flag register
	chk_a_level_low: assert property (
		(!ctl_reg[0] && !ext_request_a_pin_in) [*6] |=> ext_request_a_flag_out)
		else $error("level flag a not set by low pin");
	chk_a_level_high: assert property (
		(!ctl_reg[0] && ext_request_a_pin_in) [*6] |=> !ext_request_a_flag_out)
		else $error("level flag a not clear with high pin");
	chk_b_level_low: assert property (
		(!ctl_reg[2] && !ext_request_b_pin_in) [*6] |=> ext_request_b_flag_out)
		else $error("level flag b not set by low pin");
	chk_a_vec_clear: assert property (
		(ctl_reg[0] && ext_request_a_pin_in) [*6] ##0 (vector_request_a_in && !write_in)
		|=> !ext_request_a_flag_out)
		else $error("vector did not clear flag a");
	chk_b_vec_clear: assert property (
		(ctl_reg[2] && ext_request_b_pin_in) [*6] ##0 (vector_request_b_in && !write_in)
		|=> !ext_request_b_flag_out)
		else $error("vector did not clear flag b");
	chk_ovf_vec_clear: assert property (
		!ctl_reg[4] && !ctl_reg[6] && vector_first_unit_in && !write_in
		|=> !first_unit_overflow_flag_out)
		else $error("vector did not clear first overflow flag");
	chk_ovf_needs_run: assert property (
		$rose(first_unit_overflow_flag_out) && !$past(write_in) |-> $past(ctl_reg[4]))
		else $error("first overflow flag rose while stopped");
endmodule

bind dtc_timer_core dtc_timer_props dtc_timer_props_inst (
	.clk_in, .reset_in, .addr_in, .wdata_in, .write_in, .read_in, .rdata_out,
	.first_unit_count_pin_in, .second_unit_count_pin_in,
	.ext_request_a_pin_in, .ext_request_b_pin_in,
	.vector_first_unit_in, .vector_second_unit_in,
	.vector_request_a_in, .vector_request_b_in,
	.first_unit_overflow_flag_out, .second_unit_overflow_flag_out,
	.ext_request_a_flag_out, .ext_request_b_flag_out
);

/* File: verification/dtc_pin_partner.sv */
`timescale 1ns/1ns
// ----------------------------------------
// pins and vector pulses of the cpu side
// ----------------------------------------
module dtc_pin_partner (
	input  wire logic       clk_in,
	output logic      [3:0] pins_out,
	output logic      [3:0] vec_out
);
	// pins idle high, as pulled-up request lines
	initial begin
		pins_out = 4'hf;
		vec_out  = 4'h0;
	end

	task automatic set_pin(input int i, input logic v);
		@(posedge clk_in);
		pins_out[i] <= v;
	endtask

	// three cycles each phase so the synchroniser sees every edge
	task automatic fall(input int i, input int n);
		repeat (n) begin
			set_pin(i, 1'b0);
			repeat (2) @(posedge clk_in);
			set_pin(i, 1'b1);
			repeat (2) @(posedge clk_in);
		end
	endtask

	// one-cycle vector acknowledge
	task automatic pulse(input int i);
		@(posedge clk_in);
		vec_out[i] <= 1'b1;
		@(posedge clk_in);
		vec_out[i] <= 1'b0;
	endtask
endmodule

/* File: verification/dtc_timer_core_test.sv */
`timescale 1ns/1ns
// ----------------------------------------
// bench for the timer core
// ----------------------------------------
module dtc_timer_core_test;
	import dtc_pkg::*;
	logic       clk_in    = 1'b0;
	logic       reset_in  = 1'b1;
	logic [7:0] addr_in   = 8'h00;
	logic [7:0] wdata_in  = 8'h00;
	logic       write_in  = 1'b0;
	logic       read_in   = 1'b0;
	logic [7:0] rdata_out;
	logic [3:0] pins;
	logic [3:0] vecs;
	wire  [3:0] flags;
	logic [7:0] v;
	logic [7:0] e;
	int         mismatches  = 0;
	int         check_count = 0;

	dtc_timer_core dtc_timer_core_inst (
		.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
		.first_unit_count_pin_in(pins[0]), .second_unit_count_pin_in(pins[1]),
		.ext_request_a_pin_in(pins[2]), .ext_request_b_pin_in(pins[3]),
		.vector_first_unit_in(vecs[0]), .vector_second_unit_in(vecs[1]),
		.vector_request_a_in(vecs[2]), .vector_request_b_in(vecs[3]),
		.first_unit_overflow_flag_out(flags[0]), .second_unit_overflow_flag_out(flags[1]),
		.ext_request_a_flag_out(flags[2]), .ext_request_b_flag_out(flags[3])
	);
	dtc_pin_partner dtc_pin_partner_inst (.clk_in(clk_in), .pins_out(pins), .vec_out(vecs));

	initial begin
		forever #25 clk_in = ~clk_in;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= d;
		write_in <= 1'b1;
		@(posedge clk_in);
		write_in <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		read_in <= 1'b1;
		@(posedge clk_in);
		read_in <= 1'b0;
		#1 d = rdata_out;
	endtask

	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// preload, count n pin edges, then flags and bytes; g is the gate pin level
	task automatic ctest(input int u, input logic [7:0] tm, ct, lo, hi, input int n,
		input logic g, input logic [7:0] elo, ehi, input logic ef);
		dtc_pin_partner_inst.set_pin(2 + u, g);
		wr(ADDR_TIMER_CONTROL_AND_EXT_IRQ, 8'h00);
		wr(ADDR_TIMER_MODE_SELECT, tm);
		wr(u ? ADDR_SECOND_LOW : ADDR_FIRST_LOW, lo);
		wr(u ? ADDR_SECOND_HIGH : ADDR_FIRST_HIGH, hi);
		wr(ADDR_TIMER_CONTROL_AND_EXT_IRQ, ct);
		dtc_pin_partner_inst.fall(u, n);
		tick(5);
		check("overflow flag", {7'h00, flags[u]}, {7'h00, ef});
		dtc_pin_partner_inst.pulse(u);
		tick(1);
		check("flag after vector", {7'h00, flags[u]}, 8'h00);
		wr(ADDR_TIMER_CONTROL_AND_EXT_IRQ, 8'h00);
		dtc_pin_partner_inst.pulse(u);
		rd(u ? ADDR_SECOND_LOW : ADDR_FIRST_LOW, v);
		check("low byte", v, elo);
		rd(u ? ADDR_SECOND_HIGH : ADDR_FIRST_HIGH, v);
		check("high byte", v, ehi);
		dtc_pin_partner_inst.set_pin(2 + u, 1'b1);
		$display("counter test done unit %0d mode %h", u, tm);
	endtask

	// hang guard
	initial begin
		tick(60000);
		mismatches++;
		end_of_test();
	end

	initial begin
		tick(16);
		reset_in <= 1'b0;
		for (int a = 136; a <= 143; a++) begin
			rd(8'(a), v);
			check("reset value", v, 8'h00);
		end
		wr(ADDR_TIMER_MODE_SELECT, 8'ha5);
		rd(ADDR_TIMER_MODE_SELECT, v);
		check("mode register", v, 8'ha5);
		$display("register test done");
		ctest(0, 8'h04, 8'h10, 8'h1e, 8'hff, 2, 1, 8'h00, 8'h00, 1);
		ctest(1, 8'h50, 8'h40, 8'hff, 8'hff, 1, 1, 8'h00, 8'h00, 1);
		ctest(0, 8'h06, 8'h10, 8'hff, 8'h80, 1, 1, 8'h80, 8'h80, 1);
		ctest(1, 8'h60, 8'h40, 8'hfe, 8'h10, 2, 1, 8'h10, 8'h10, 1);
		ctest(1, 8'h70, 8'h40, 8'h05, 8'h00, 3, 1, 8'h05, 8'h00, 0);
		ctest(0, 8'h04, 8'h00, 8'h00, 8'h00, 3, 1, 8'h00, 8'h00, 0);
		ctest(0, 8'h0c, 8'h10, 8'h00, 8'h00, 3, 0, 8'h00, 8'h00, 0);
		ctest(0, 8'h0c, 8'h10, 8'h00, 8'h00, 3, 1, 8'h03, 8'h00, 0);
		ctest(1, 8'hd0, 8'h40, 8'h00, 8'h00, 3, 0, 8'h00, 8'h00, 0);
		ctest(1, 8'hd0, 8'h40, 8'h00, 8'h00, 3, 1, 8'h03, 8'h00, 0);
		ctest(1, 8'h53, 8'h40, 8'h05, 8'h00, 3, 1, 8'h05, 8'h00, 0);
		// prescaler phase is free running, so allow one count either way
		for (int p = 0; p < 2; p++) begin
			wr(ADDR_PRESCALE_CONFIG_REG, p ? 8'h08 : 8'h00);
			wr(ADDR_TIMER_MODE_SELECT, 8'h01);
			wr(ADDR_FIRST_LOW, 8'h00);
			wr(ADDR_FIRST_HIGH, 8'h00);
			wr(ADDR_TIMER_CONTROL_AND_EXT_IRQ, 8'h10);
			tick(48);
			wr(ADDR_TIMER_CONTROL_AND_EXT_IRQ, 8'h00);
			rd(ADDR_FIRST_LOW, v);
			e = p ? 8'h0c : 8'h04;
			check("prescaled count", {7'h00, v >= e - 8'h01 && v <= e + 8'h01}, 8'h01);
			$display("prescale test done select %0d", p);
		end
		// split mode: first high byte runs on the second run bit and fast prescale
		wr(ADDR_PRESCALE_CONFIG_REG, 8'h10);
		wr(ADDR_TIMER_MODE_SELECT, 8'h03);
		wr(ADDR_FIRST_LOW, 8'h00);
		wr(ADDR_FIRST_HIGH, 8'hfe);
		wr(ADDR_SECOND_LOW, 8'h05);
		wr(ADDR_TIMER_CONTROL_AND_EXT_IRQ, 8'h40);
		tick(48);
		check("split overflow flag", {7'h00, flags[1]}, 8'h01);
		check("first flag idle", {7'h00, flags[0]}, 8'h00);
		wr(ADDR_TIMER_CONTROL_AND_EXT_IRQ, 8'h00);
		rd(ADDR_FIRST_HIGH, v);
		e = 8'h0a;
		check("split high count", {7'h00, v >= e - 8'h01 && v <= e + 8'h01}, 8'h01);
		rd(ADDR_FIRST_LOW, v);
		check("split low held", v, 8'h00);
		rd(ADDR_SECOND_LOW, v);
		check("second unit held", v, 8'h05);
		$display("split test done");
		// request a then request b: level mode, then edge mode
		for (int i = 0; i < 2; i++) begin
			wr(ADDR_TIMER_CONTROL_AND_EXT_IRQ, 8'h00);
			dtc_pin_partner_inst.set_pin(2 + i, 1'b0);
			tick(8);
			check("level flag low pin", {7'h00, flags[2 + i]}, 8'h01);
			dtc_pin_partner_inst.set_pin(2 + i, 1'b1);
			wr(ADDR_TIMER_CONTROL_AND_EXT_IRQ, i ? 8'h08 : 8'h02);
			tick(8);
			check("level flag high pin", {7'h00, flags[2 + i]}, 8'h00);
			wr(ADDR_TIMER_CONTROL_AND_EXT_IRQ, i ? 8'h04 : 8'h01);
			dtc_pin_partner_inst.fall(2 + i, 1);
			tick(8);
			check("edge flag", {7'h00, flags[2 + i]}, 8'h01);
			dtc_pin_partner_inst.pulse(2 + i);
			tick(1);
			check("edge flag after vector", {7'h00, flags[2 + i]}, 8'h00);
			wr(ADDR_TIMER_CONTROL_AND_EXT_IRQ, i ? 8'h0c : 8'h03);
			tick(1);
			check("edge flag set by write", {7'h00, flags[2 + i]}, 8'h01);
			$display("request test done input %0d", i);
		end
		end_of_test();
	end
endmodule
